// file: verilog/dnhs_pkg.sv
// Package: register map, field positions and reset values of the next-hop selector
package dnhs_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS      = 8'h00;
    localparam logic [7:0]  DEST_PORT_OFS = 8'h04;
    localparam logic [7:0]  GATEWAY_OFS   = 8'h08;
    localparam logic [7:0]  MASK_OFS      = 8'h0C;
    localparam logic [7:0]  OWN_ADDR_OFS  = 8'h10;
    localparam logic [7:0]  DEST_ADDR_OFS = 8'h14;
    localparam logic [7:0]  STATUS_OFS    = 8'h18;
    localparam logic [7:0]  NEXT_HOP_OFS  = 8'h1C;
    localparam logic [7:0]  CONN_ADDR_OFS = 8'h20;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_AUTO_BIT = 2;
    localparam int CTRL_GO_BIT   = 3;
    localparam int CTRL_OVR_BIT  = 4;
    localparam int CTRL_RST_BIT  = 5;

    // ------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------
    localparam int STAT_LOCAL_BIT = 0;
    localparam int STAT_MASK_BIT  = 1;
    localparam int STAT_AUTO_BIT  = 2;

    // ------------------------------------------------------------
    // Reset values and the server-only routing mode code
    // ------------------------------------------------------------
    localparam logic [1:0]  MODE_RST      = 2'h1;
    localparam logic [15:0] DEST_PORT_RST = 16'h03E9;
    localparam logic [31:0] GATEWAY_RST   = 32'h7F000001;
    localparam logic [31:0] MASK_RST      = 32'hFFFFFF00;
    localparam logic [31:0] OWN_ADDR_RST  = 32'h7F000003;
    localparam logic [31:0] DEST_ADDR_RST = 32'h7F000002;
    localparam logic [1:0]  MODE_SERVER   = 2'h0;

endpackage

// file: verilog/dnhs_route_if.sv
// Interface: addresses into the locality check and the next hop out of it
`timescale 1ns/1ns
interface dnhs_route_if;
    logic [31:0] own_addr;
    logic [31:0] dest_addr;
    logic [31:0] subnet_mask;
    logic [31:0] gateway_addr;
    logic        is_local;
    logic [31:0] next_hop;

    modport ctl (output own_addr, output dest_addr, output subnet_mask,
                 output gateway_addr, input is_local, input next_hop);
    modport rte (input own_addr, input dest_addr, input subnet_mask,
                 input gateway_addr, output is_local, output next_hop);
endinterface

// file: verilog/dnhs_route.sv
// Locality test and next-hop selection
`timescale 1ns/1ns
module dnhs_route (
    dnhs_route_if.rte rif
);
    // ------------------------------------------------------------
    // Masked compare and select
    // ------------------------------------------------------------
    logic [31:0] own_masked;
    logic [31:0] dest_masked;

    assign own_masked   = rif.own_addr & rif.subnet_mask;      // see (RL5)
    assign dest_masked  = rif.dest_addr & rif.subnet_mask;     // see (RL5)
    assign rif.is_local = (own_masked == dest_masked);         // see (RL5)
    // Gateway only for a foreign subnet
    assign rif.next_hop = rif.is_local ? rif.dest_addr : rif.gateway_addr; // see (RL6) see (RL7)
endmodule

// file: verilog/dnhs_mask_chk.sv
// Netmask shape check: ones from the top, zeros below
`timescale 1ns/1ns
module dnhs_mask_chk (
    input  wire logic [31:0] mask_i,
    output logic             ok_o
);
    // ------------------------------------------------------------
    // A one below a zero breaks the mask
    // ------------------------------------------------------------
    logic [30:0] bad;

    for (genvar i = 0; i < 31; i++) begin : g_bit
        assign bad[i] = mask_i[i] & ~mask_i[i+1];              // see (RL8)
    end

    assign ok_o = ~|bad;
endmodule

// file: verilog/dnhs_top.sv
// Destination next-hop selector with Wishbone register file
// ------------------------------------------------------------
// Notes on behaviour
// (RL1) Destination port holds any value 0..65535
// (RL2) Outgoing connection uses stored destination port
// (RL3) Remote address from active destination value
// (RL4) Routing mode zero: no outgoing connections
// (RL5) Mask own and destination, compare equal
// (RL6) Equal goes direct, else via gateway
// (RL7) Gateway only for foreign-subnet destinations
// (RL8) Valid mask: leading ones, trailing zeros
// (RL9) Auto addressing overwrites gateway when supplied
// (RL10) Auto addressing overwrites mask when supplied
// (RL11) Working copies loaded only at restart
// ------------------------------------------------------------
`timescale 1ns/1ns
module dnhs_top (
    input  wire logic        MCLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        DHCP_GW_VALID_I,
    input  wire logic [31:0] DHCP_GW_I,
    input  wire logic        DHCP_MASK_VALID_I,
    input  wire logic [31:0] DHCP_MASK_I,
    output logic             CONN_REQ_O,
    output logic      [31:0] CONN_ADDR_O,
    output logic      [15:0] CONN_PORT_O,
    output logic             CONN_DIRECT_O
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
        logic [1:0]  routing_mode_setting;
        logic        auto_addressing_enable;
        logic [15:0] dest_port_setting;
        logic [31:0] gateway_addr_setting;
        logic [31:0] subnet_mask_setting;
        logic [31:0] own_addr_setting;
        logic [31:0] dest_addr_setting;
        logic [31:0] conn_addr;
        logic [15:0] wrk_port;
        logic [31:0] wrk_gw;
        logic [31:0] wrk_mask;
        logic [31:0] wrk_own;
        logic [31:0] wrk_dest;
        logic        req;
        logic [31:0] req_addr;
        logic [15:0] req_port;
        logic        req_direct;
    } dnhs_state_type;

    dnhs_state_type st_r;
    dnhs_state_type st_nxt;

    dnhs_route_if rif ();
    logic         mask_ok;
    logic         wr_acc;
    logic         go;
    logic         ovr;
    logic         restart;

    dnhs_route u_route (
        .rif (rif.rte)
    );

    dnhs_mask_chk u_mask_chk (
        .mask_i (st_r.wrk_mask),
        .ok_o   (mask_ok)
    );

    // ------------------------------------------------------------
    // Byte-lane merge
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Strobes of a control write
    // ------------------------------------------------------------
    assign wr_acc  = WB_CYC_I & WB_STB_I & WB_WE_I & st_r.ack;
    assign go      = wr_acc && (WB_ADR_I == dnhs_pkg::CTRL_OFS) && WB_SEL_I[0]
                     && WB_DAT_I[dnhs_pkg::CTRL_GO_BIT];
    assign ovr     = WB_DAT_I[dnhs_pkg::CTRL_OVR_BIT];
    assign restart = wr_acc && (WB_ADR_I == dnhs_pkg::CTRL_OFS) && WB_SEL_I[0]
                     && WB_DAT_I[dnhs_pkg::CTRL_RST_BIT];

    // ------------------------------------------------------------
    // Route inputs: working copies and active destination
    // ------------------------------------------------------------
    assign rif.own_addr     = st_r.wrk_own;
    assign rif.subnet_mask  = st_r.wrk_mask;
    assign rif.gateway_addr = st_r.wrk_gw;
    assign rif.dest_addr    = (go && ovr) ? st_r.conn_addr : st_r.wrk_dest; // see (RL3)

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] rd;
        rd     = 32'h00000000;
        st_nxt = st_r;

        // Bus answer: ack one cycle after the request, dropped next
        st_nxt.ack = WB_CYC_I & WB_STB_I & ~st_r.ack;
        case (WB_ADR_I)
            dnhs_pkg::CTRL_OFS: begin
                rd[dnhs_pkg::CTRL_MODE_LSB +: 2] = st_r.routing_mode_setting;
                rd[dnhs_pkg::CTRL_AUTO_BIT]      = st_r.auto_addressing_enable;
            end
            dnhs_pkg::DEST_PORT_OFS: rd[15:0] = st_r.dest_port_setting;
            dnhs_pkg::GATEWAY_OFS:   rd       = st_r.gateway_addr_setting;
            dnhs_pkg::MASK_OFS:      rd       = st_r.subnet_mask_setting;
            dnhs_pkg::OWN_ADDR_OFS:  rd       = st_r.own_addr_setting;
            dnhs_pkg::DEST_ADDR_OFS: rd       = st_r.dest_addr_setting;
            dnhs_pkg::STATUS_OFS: begin
                rd[dnhs_pkg::STAT_LOCAL_BIT] = rif.is_local;
                rd[dnhs_pkg::STAT_MASK_BIT]  = mask_ok;
                rd[dnhs_pkg::STAT_AUTO_BIT]  = st_r.auto_addressing_enable;
            end
            dnhs_pkg::NEXT_HOP_OFS:  rd       = rif.next_hop;
            dnhs_pkg::CONN_ADDR_OFS: rd       = st_r.conn_addr;
            default:                 rd       = 32'h00000000;
        endcase
        if (WB_CYC_I && WB_STB_I && !st_r.ack) begin
            st_nxt.dat = rd;
        end

        // Register writes at the acknowledging edge
        if (wr_acc) begin
            case (WB_ADR_I)
                dnhs_pkg::CTRL_OFS: begin
                    if (WB_SEL_I[0]) begin
                        st_nxt.routing_mode_setting =
                            WB_DAT_I[dnhs_pkg::CTRL_MODE_LSB +: 2];
                        st_nxt.auto_addressing_enable = WB_DAT_I[dnhs_pkg::CTRL_AUTO_BIT];
                    end
                end
                dnhs_pkg::DEST_PORT_OFS: begin
                    st_nxt.dest_port_setting = 16'(merge({16'h0000, st_r.dest_port_setting},
                                                         WB_DAT_I, WB_SEL_I)); // see (RL1)
                end
                dnhs_pkg::GATEWAY_OFS: begin
                    st_nxt.gateway_addr_setting =
                        merge(st_r.gateway_addr_setting, WB_DAT_I, WB_SEL_I);
                end
                dnhs_pkg::MASK_OFS: begin
                    st_nxt.subnet_mask_setting =
                        merge(st_r.subnet_mask_setting, WB_DAT_I, WB_SEL_I);
                end
                dnhs_pkg::OWN_ADDR_OFS: begin
                    st_nxt.own_addr_setting = merge(st_r.own_addr_setting, WB_DAT_I, WB_SEL_I);
                end
                dnhs_pkg::DEST_ADDR_OFS: begin
                    st_nxt.dest_addr_setting = merge(st_r.dest_addr_setting, WB_DAT_I, WB_SEL_I);
                end
                dnhs_pkg::CONN_ADDR_OFS: begin
                    st_nxt.conn_addr = merge(st_r.conn_addr, WB_DAT_I, WB_SEL_I);
                end
                default: begin
                end
            endcase
        end

        // Server-supplied values win over a software write
        if (st_r.auto_addressing_enable && DHCP_GW_VALID_I) begin
            st_nxt.gateway_addr_setting = DHCP_GW_I;               // see (RL9)
        end
        if (st_r.auto_addressing_enable && DHCP_MASK_VALID_I) begin
            st_nxt.subnet_mask_setting = DHCP_MASK_I;              // see (RL10)
        end

        // Working copies change only on a restart
        if (restart) begin
            st_nxt.wrk_port = st_r.dest_port_setting;              // see (RL11)
            st_nxt.wrk_gw   = st_r.gateway_addr_setting;           // see (RL11)
            st_nxt.wrk_mask = st_r.subnet_mask_setting;            // see (RL11)
            st_nxt.wrk_own  = st_r.own_addr_setting;               // see (RL11)
            st_nxt.wrk_dest = st_r.dest_addr_setting;              // see (RL11)
        end

        // Connection request, never in server-only mode
        st_nxt.req = go && (st_r.routing_mode_setting != dnhs_pkg::MODE_SERVER); // see (RL4)
        if (st_nxt.req) begin
            st_nxt.req_addr   = rif.next_hop;                      // see (RL6)
            st_nxt.req_port   = st_r.wrk_port;                     // see (RL2)
            st_nxt.req_direct = rif.is_local;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            st_r                        <= '0;
            st_r.routing_mode_setting   <= dnhs_pkg::MODE_RST;
            st_r.dest_port_setting      <= dnhs_pkg::DEST_PORT_RST;
            st_r.gateway_addr_setting   <= dnhs_pkg::GATEWAY_RST;
            st_r.subnet_mask_setting    <= dnhs_pkg::MASK_RST;
            st_r.own_addr_setting       <= dnhs_pkg::OWN_ADDR_RST;
            st_r.dest_addr_setting      <= dnhs_pkg::DEST_ADDR_RST;
            st_r.wrk_port               <= dnhs_pkg::DEST_PORT_RST;
            st_r.wrk_gw                 <= dnhs_pkg::GATEWAY_RST;
            st_r.wrk_mask               <= dnhs_pkg::MASK_RST;
            st_r.wrk_own                <= dnhs_pkg::OWN_ADDR_RST;
            st_r.wrk_dest               <= dnhs_pkg::DEST_ADDR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign WB_ACK_O      = st_r.ack;
    assign WB_DAT_O      = st_r.dat;
    assign CONN_REQ_O    = st_r.req;
    assign CONN_ADDR_O   = st_r.req_addr;
    assign CONN_PORT_O   = st_r.req_port;
    assign CONN_DIRECT_O = st_r.req_direct;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (SYS_RST_I);

    sequence s_port_write;
        wr_acc && (WB_ADR_I == dnhs_pkg::DEST_PORT_OFS) && (WB_SEL_I[1:0] == 2'h3);
    endsequence

    property p_port_full_range;
        logic [15:0] v;
        (s_port_write, v = WB_DAT_I[15:0]) |=> (st_r.dest_port_setting == v);
    endproperty
    a_port_full_range: assert property (p_port_full_range)               // see (RL1)
        else $error("Destination port not stored as written");

    property p_port_used;
        CONN_REQ_O |-> (CONN_PORT_O == st_r.wrk_port);
    endproperty
    a_port_used: assert property (p_port_used)                           // see (RL2)
        else $error("Connection port differs from stored port");

    property p_override_addr;
        (go && ovr && (st_r.routing_mode_setting != dnhs_pkg::MODE_SERVER)) ##1
            CONN_DIRECT_O |-> (CONN_ADDR_O == $past(st_r.conn_addr));
    endproperty
    a_override_addr: assert property (p_override_addr)                   // see (RL3)
        else $error("Given connect address not used");

    property p_server_silent;
        (st_r.routing_mode_setting == dnhs_pkg::MODE_SERVER) |=> !CONN_REQ_O;
    endproperty
    a_server_silent: assert property (p_server_silent)                   // see (RL4)
        else $error("Request issued in server-only mode");

    property p_direct_is_local;
        CONN_REQ_O && CONN_DIRECT_O |->
            ((st_r.wrk_own & st_r.wrk_mask) == (CONN_ADDR_O & st_r.wrk_mask));
    endproperty
    a_direct_is_local: assert property (p_direct_is_local)               // see (RL5)
        else $error("Direct hop outside the local subnet");

    property p_foreign_via_gw;
        CONN_REQ_O && !CONN_DIRECT_O |-> (CONN_ADDR_O == st_r.wrk_gw);
    endproperty
    a_foreign_via_gw: assert property (p_foreign_via_gw)                 // see (RL6)
        else $error("Foreign destination not sent to gateway");

    property p_gw_only_foreign;
        (go && !ovr && (st_r.routing_mode_setting != dnhs_pkg::MODE_SERVER)
            && ((st_r.wrk_own & st_r.wrk_mask) == (st_r.wrk_dest & st_r.wrk_mask)))
            |=> CONN_REQ_O && CONN_DIRECT_O && (CONN_ADDR_O == $past(st_r.wrk_dest));
    endproperty
    a_gw_only_foreign: assert property (p_gw_only_foreign)               // see (RL7)
        else $error("Local destination routed through gateway");

    property p_mask_shape;
        logic [31:0] inv;
        (1'b1, inv = ~st_r.wrk_mask) |-> (mask_ok == ((inv & (inv + 32'h00000001)) == 32'h0));
    endproperty
    a_mask_shape: assert property (p_mask_shape)                         // see (RL8)
        else $error("Netmask shape check wrong");

    property p_auto_gw;
        (st_r.auto_addressing_enable && DHCP_GW_VALID_I)
            |=> (st_r.gateway_addr_setting == $past(DHCP_GW_I));
    endproperty
    a_auto_gw: assert property (p_auto_gw)                               // see (RL9)
        else $error("Supplied gateway not stored");

    property p_auto_mask;
        (st_r.auto_addressing_enable && DHCP_MASK_VALID_I)
            |=> (st_r.subnet_mask_setting == $past(DHCP_MASK_I));
    endproperty
    a_auto_mask: assert property (p_auto_mask)                           // see (RL10)
        else $error("Supplied netmask not stored");

    property p_work_frozen;
        !restart |=> $stable(st_r.wrk_port) && $stable(st_r.wrk_gw)
                     && $stable(st_r.wrk_mask) && $stable(st_r.wrk_dest);
    endproperty
    a_work_frozen: assert property (p_work_frozen)                       // see (RL11)
        else $error("Working copy changed without restart");

    property p_ack_once;
        (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("Bus ack not a single cycle");
endmodule

// file: test/dnhs_remote_host.sv
// Model of the remote host that receives outgoing connection attempts
`timescale 1ns/1ns
module dnhs_remote_host (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        conn_req_i,
    input  wire logic [31:0] conn_addr_i,
    input  wire logic [15:0] conn_port_i,
    output int               n_conn_o,
    output logic      [31:0] last_addr_o,
    output logic      [15:0] last_port_o
);
    // ------------------------------------------------------------
    // Accept every attempt and remember the caller's target
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            n_conn_o    <= 0;
            last_addr_o <= 32'h0;
            last_port_o <= 16'h0;
        end else if (conn_req_i === 1'b1) begin
            n_conn_o    <= n_conn_o + 1;
            last_addr_o <= conn_addr_i;
            last_port_o <= conn_port_i;
        end
    end
endmodule

// file: test/tb_destination_next_hop_select.sv
// Testbench: register access, locality test and next-hop selection
`timescale 1ns/1ns
module tb_destination_next_hop_select;
    logic        clk, rst, cyc, stb, we, ack, gw_v, mk_v, req, cdir;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_w, dat_r, gw, mk, caddr, haddr;
    logic [15:0] cport, hport;
    logic [31:0] s [0:8];
    logic [31:0] wk [0:8];
    logic [31:0] rd_q [$];
    logic [63:0] cn_q [$];
    logic [63:0] lst;
    int          n_mismatch, checks, n_exp, n_conn, i, sh;
    integer      seed;

    dnhs_top dnhs_top_inst (.MCLK_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r),
        .WB_ACK_O(ack), .DHCP_GW_VALID_I(gw_v), .DHCP_GW_I(gw), .DHCP_MASK_VALID_I(mk_v),
        .DHCP_MASK_I(mk), .CONN_REQ_O(req), .CONN_ADDR_O(caddr), .CONN_PORT_O(cport),
        .CONN_DIRECT_O(cdir));
    dnhs_remote_host dnhs_remote_host_inst (.clk_i(clk), .rst_i(rst), .conn_req_i(req),
        .conn_addr_i(caddr), .conn_port_i(cport), .n_conn_o(n_conn), .last_addr_o(haddr),
        .last_port_o(hport));

    // ------------------------------------------------------------
    // Clock, compare and verdict
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done;
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic is_local(input logic [31:0] d);
        return (wk[4] & wk[3]) == (d & wk[3]);
    endfunction

    function automatic logic [31:0] rd_exp(input int idx);
        logic [31:0] inv;
        inv = ~wk[3];
        case (idx)
            0, 1, 2, 3, 4, 5, 8: return s[idx];
            6: return {29'h0, s[0][2], ((inv & (inv + 32'h1)) == 32'h0), is_local(wk[5])};
            7: return is_local(wk[5]) ? wk[5] : wk[2];
            default: return 32'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Bus master and control writes
    // ------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat_w <= d;
        if (!w) rd_q.push_back(d);
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (w && a[1:0] == 2'h0 && a <= 8'h20 && a != 8'h18 && a != 8'h1C)
            s[a[7:2]] = d & (a == 8'h0 ? 32'h7 : a == 8'h4 ? 32'hFFFF : 32'hFFFFFFFF);
    endtask

    task automatic rd(input int idx);
        wb(1'b0, 8'(idx * 4), rd_exp(idx));
    endtask

    task automatic ctrl(input logic [1:0] md, input logic au, go, ovr, rs);
        logic [31:0] d;
        logic [1:0]  om;
        // Routing mode in force is the one held before this write
        om = s[0][1:0];
        wb(1'b1, dnhs_pkg::CTRL_OFS, {26'h0, rs, ovr, go, au, md});
        if (rs) wk = s;
        if (go && om != dnhs_pkg::MODE_SERVER) begin
            d = ovr ? s[8] : wk[5];
            lst = {15'h0, is_local(d), wk[1][15:0], is_local(d) ? d : wk[2]};
            cn_q.push_back(lst);
            n_exp++;
        end
    endtask

    // ------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0)
            chk("read data", dat_r, rd_q.size() ? rd_q.pop_front() : 32'hDEAD);
        if (req === 1'b1)
            chk("connection", {15'h0, cdir, cport, caddr},
                cn_q.size() ? cn_q.pop_front() : 64'h1);
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h3e31;
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h0;
        sel = 4'h0;
        dat_w = 32'h0;
        gw_v = 1'b0;
        mk_v = 1'b0;
        gw = 32'h0;
        mk = 32'h0;
        n_mismatch = 0;
        checks = 0;
        n_exp = 0;
        lst = 64'h0;
        s = '{32'h1, 32'(dnhs_pkg::DEST_PORT_RST), dnhs_pkg::GATEWAY_RST, dnhs_pkg::MASK_RST,
              dnhs_pkg::OWN_ADDR_RST, dnhs_pkg::DEST_ADDR_RST, 32'h0, 32'h0, 32'h0};
        wk = s;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i <= 9; i++) rd(i);
        wb(1'b0, 8'hFC, 32'h0);
        ctrl(2'h1, 1'b0, 1'b1, 1'b0, 1'b0);
        wb(1'b1, dnhs_pkg::DEST_PORT_OFS, 32'hABCDFFFF);
        wb(1'b1, dnhs_pkg::DEST_ADDR_OFS, 32'h0A000001);
        rd(1);
        ctrl(2'h2, 1'b0, 1'b1, 1'b0, 1'b0);
        ctrl(2'h2, 1'b0, 1'b0, 1'b0, 1'b1);
        ctrl(2'h3, 1'b0, 1'b1, 1'b0, 1'b0);
        wb(1'b1, dnhs_pkg::DEST_PORT_OFS, 32'h0);
        wb(1'b1, dnhs_pkg::CONN_ADDR_OFS, 32'h7F0000AB);
        ctrl(2'h1, 1'b0, 1'b0, 1'b0, 1'b1);
        ctrl(2'h1, 1'b0, 1'b1, 1'b1, 1'b0);
        for (i = 0; i < 4; i++) ctrl(2'(i), 1'b0, 1'b1, 1'b0, 1'b0);
        ctrl(2'h1, 1'b1, 1'b0, 1'b0, 1'b0);
        @(posedge clk);
        gw_v <= 1'b1;
        gw <= $random(seed);
        mk_v <= 1'b1;
        mk <= 32'hFFFF0000;
        @(posedge clk);
        gw_v <= 1'b0;
        mk_v <= 1'b0;
        s[2] = gw;
        s[3] = mk;
        rd(2);
        rd(3);
        ctrl(2'h1, 1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge clk);
        gw_v <= 1'b1;
        gw <= ~gw;
        mk_v <= 1'b1;
        mk <= 32'hF0F0F0F0;
        @(posedge clk);
        gw_v <= 1'b0;
        mk_v <= 1'b0;
        rd(2);
        rd(3);
        wb(1'b1, dnhs_pkg::MASK_OFS, 32'hFF00FF00);
        ctrl(2'h1, 1'b0, 1'b0, 1'b0, 1'b1);
        rd(6);
        for (i = 0; i < 8; i++) begin
            sh = $unsigned($random(seed)) % 33;
            wb(1'b1, dnhs_pkg::MASK_OFS, 32'hFFFFFFFF << sh);
            wb(1'b1, dnhs_pkg::OWN_ADDR_OFS, $random(seed));
            wb(1'b1, dnhs_pkg::DEST_ADDR_OFS, s[4] ^ (32'($random(seed)) >> (i * 4)));
            wb(1'b1, dnhs_pkg::GATEWAY_OFS, $random(seed));
            ctrl(2'h2, 1'b0, 1'b0, 1'b0, 1'b1);
            rd(6);
            rd(7);
            ctrl(2'h2, 1'b0, 1'b1, 1'b0, 1'b0);
        end
        repeat (8) @(posedge clk);
        chk("connection count", n_conn, n_exp);
        chk("host address", haddr, lst[31:0]);
        chk("host port", hport, lst[47:32]);
        chk("pending notes", rd_q.size() + cn_q.size(), 0);
        test_done();
    end
endmodule
